// >>> core/remap_pkg.sv
// Constants shared by the peripheral input remap block and its shadow memory
package remap_pkg;
  localparam int NUM_PINS = 46;
  localparam int NUM_BIDIR = 32;
  localparam int NUM_INPUTS = 37;
  localparam int SEL_W = 6;
  localparam int REG_IDX_W = 5;
  localparam int REG_DATA_W = 16;
  localparam int WORD_W = 12;
  localparam int MEM_DEPTH = 32;
  localparam logic [REG_IDX_W-1:0] REG_LAST = 5'h1D;
  localparam logic [SEL_W-1:0] SEL_RESET = 6'h3F;
  localparam logic [SEL_W-1:0] PIN_LAST = 6'h2D;
  localparam int LO_LSB = 0;
  localparam int HI_LSB = 8;
  localparam logic [NUM_PINS-1:0] IMPL_PIN_MASK = 46'h3FFF_FFFF_FFFF;
  // Input order: ext_irq 1-4, timer1-5 clocks, capture 1-8, compare faults A/B,
  // capture 9, uart3 rx, uart1 cts/rx, uart2 cts/rx, spi1 clk/data/select,
  // uart3 cts, spi2 clk/data/select, spi3 clk, uart4 cts/rx, spi3 data/select
  localparam logic [REG_IDX_W-1:0] FIELD_REG [NUM_INPUTS] = '{
    5'h00, 5'h01, 5'h01, 5'h02, 5'h02, 5'h03, 5'h03, 5'h04, 5'h04, 5'h07,
    5'h07, 5'h08, 5'h08, 5'h09, 5'h09, 5'h0A, 5'h0A, 5'h0B, 5'h0B, 5'h0F,
    5'h11, 5'h12, 5'h12, 5'h13, 5'h13, 5'h14, 5'h14, 5'h15, 5'h15, 5'h16,
    5'h16, 5'h17, 5'h17, 5'h1B, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [NUM_INPUTS-1:0] FIELD_HI = 37'h05_5545_5554;
  // Idle levels: receive, select and clear-to-send rest high
  localparam logic [NUM_INPUTS-1:0] INACTIVE_LEVEL = 37'h16_99F0_0000;
endpackage

// >>> core/route_mem_if.sv
// Port bundle between the remap control logic and its shadow memory
`timescale 1ns/1ps
interface route_mem_if;
  logic wr_en;
  logic [remap_pkg::REG_IDX_W-1:0] wr_addr;
  logic [remap_pkg::WORD_W-1:0] wr_data;
  logic [remap_pkg::REG_IDX_W-1:0] rd_addr;
  logic [remap_pkg::WORD_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> core/route_shadow_mem.sv
// Shadow copy of the input route registers with registered read data
`timescale 1ns/1ps
module route_shadow_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  route_mem_if.mem port
);
  logic [remap_pkg::WORD_W-1:0] mem_q [remap_pkg::MEM_DEPTH];
  logic [remap_pkg::WORD_W-1:0] rd_q;

  assign port.rd_data = rd_q;

  // Reset loads every live half with the unmapped field value, as the live fields
  // hold; a plain zero here would raise a false mismatch right after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < remap_pkg::MEM_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      for (int p = 0; p < remap_pkg::NUM_INPUTS; p++) begin
        if (remap_pkg::FIELD_HI[p]) begin
          mem_q[remap_pkg::FIELD_REG[p]][remap_pkg::WORD_W-1:remap_pkg::SEL_W] <= remap_pkg::SEL_RESET;
        end else begin
          mem_q[remap_pkg::FIELD_REG[p]][remap_pkg::SEL_W-1:0] <= remap_pkg::SEL_RESET;
        end
      end
      rd_q <= '0;
    end else if (ce) begin
      if (port.wr_en) begin
        mem_q[port.wr_addr] <= port.wr_data;
      end
      rd_q <= mem_q[port.rd_addr];
    end
  end
endmodule

// >>> core/peripheral_input_remap.sv
// Input half of the peripheral-to-pin remap matrix
//
// Contract
// [RULE1] Up to 46 remappable pins are served.
// [RULE2] Pins 0 to 31 serve remapped inputs and outputs.
// [RULE3] Pins 32 to 45 are input sources only, never driven.
// [RULE4] No default pin: inputs stay unconnected until a field is programmed.
// [RULE5] An active remapped function outranks port logic and other peripherals.
// [RULE6] Analog functions on a pin always outrank remapped functions.
// [RULE7] Each input has a 6-bit field; value n routes pin n.
// [RULE8] Each input route register holds two selection fields. Here registers 0x00, 0x0F, 0x11, 0x1C and 0x1D hold only one.
// [RULE9] Input and output routing use separate register sets.
// [RULE10] The fixed list of interrupt, capture, fault, SPI, timer, UART inputs.
// [RULE11] No routing for two-wire bus, change notice, clock alarm, analog.
// [RULE12] Legal field values equal the implemented pin count.
// [RULE13] Established routing is guarded against accidental change.
// [RULE14] A field naming an unimplemented pin or above 45 leaves input unmapped.
// [RULE15] With the write lock set, writes complete but change nothing.
// [RULE16] Shadow copies are compared; a change raises a mismatch reset.
// [RULE17] Several inputs may share one pin; its level fans out to all.
// [RULE18] Unmapped inputs see a constant inactive level.
// [RULE19] Reads return the last value accepted into each field.
`timescale 1ns/1ps
module peripheral_input_remap (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [remap_pkg::NUM_PINS-1:0] remap_pin_in,
  input wire logic [remap_pkg::NUM_PINS-1:0] analog_enable,
  input wire logic route_write_lock,
  input wire logic cfg_wr_en,
  input wire logic [remap_pkg::REG_IDX_W-1:0] cfg_wr_index,
  input wire logic [remap_pkg::REG_DATA_W-1:0] cfg_wr_data,
  input wire logic cfg_rd_en,
  input wire logic [remap_pkg::REG_IDX_W-1:0] cfg_rd_index,
  output logic [remap_pkg::REG_DATA_W-1:0] cfg_rd_data,
  output logic [remap_pkg::NUM_INPUTS-1:0] periph_in,
  output logic [remap_pkg::NUM_PINS-1:0] pin_remap_claim,
  output logic config_mismatch_reset
);
  localparam int NP = remap_pkg::NUM_PINS;
  localparam int NI = remap_pkg::NUM_INPUTS;
  localparam int SW = remap_pkg::SEL_W;
  localparam int WW = remap_pkg::WORD_W;

  logic [NP-1:0] pin_meta_q;
  logic [NP-1:0] pin_sync_q;
  logic [NI-1:0][SW-1:0] sel_q;
  logic [NI-1:0][SW-1:0] sel_d;
  logic [NI-1:0][SW-1:0] pin_idx;
  logic [NI-1:0] sel_ok;
  logic [NI-1:0] route_live;
  logic [NI-1:0] periph_d;
  logic [NI-1:0] periph_q;
  logic [NP-1:0] claim_d;
  logic [NP-1:0] claim_q;
  logic [remap_pkg::REG_DATA_W-1:0] rd_q;
  logic [remap_pkg::REG_IDX_W-1:0] scan_q;
  logic [remap_pkg::REG_IDX_W-1:0] cmp_idx_q;
  logic cmp_ok_q;
  logic mismatch_q;
  logic [WW-1:0] rd_word;
  logic [WW-1:0] cmp_word;
  logic [WW-1:0] wr_word;
  logic wr_ok;
  logic mismatch_hit;
  logic [remap_pkg::REG_IDX_W-1:0] scan_next;

  route_mem_if shadow ();

  route_shadow_mem u_shadow (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .port(shadow.mem)
  );

  // Packs the one or two fields of one route register; unused bits read as zero
  function automatic logic [WW-1:0] word_of(input logic [remap_pkg::REG_IDX_W-1:0] idx,
                                            input logic [NI-1:0][SW-1:0] sel);
    logic [WW-1:0] w;
    w = '0;
    for (int p = 0; p < NI; p++) begin
      if (remap_pkg::FIELD_REG[p] == idx) begin
        if (remap_pkg::FIELD_HI[p]) begin
          w[WW-1:SW] = sel[p];
        end else begin
          w[SW-1:0] = sel[p];
        end
      end
    end
    return w;
  endfunction

  // Pins come from outside the clock domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else if (ce) begin
      pin_meta_q <= remap_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Lock drops writes silently; no error is signalled
  assign wr_ok = cfg_wr_en & ~route_write_lock; // RULE15 RULE13
  assign wr_word = {cfg_wr_data[remap_pkg::HI_LSB +: SW], cfg_wr_data[remap_pkg::LO_LSB +: SW]};

  // One selection field per peripheral input, at most two per register
  // Routing reads only the synced pins, so a pin edge never races the field
  // decode; the cost is two cycles of extra latency on every routed input
  for (genvar p = 0; p < NI; p++) begin : g_field
    assign sel_d[p] = (wr_ok && cfg_wr_index == remap_pkg::FIELD_REG[p])
                    ? (remap_pkg::FIELD_HI[p] ? wr_word[WW-1:SW] : wr_word[SW-1:0])
                    : sel_q[p]; // RULE7 RULE8 RULE19
    assign sel_ok[p] = (sel_q[p] <= remap_pkg::PIN_LAST)
                     && remap_pkg::IMPL_PIN_MASK[sel_q[p]]; // RULE12 RULE14 RULE1
    // Clamped index keeps an invalid field from selecting beyond the pin vector
    assign pin_idx[p] = sel_ok[p] ? sel_q[p] : '0;
    assign route_live[p] = sel_ok[p] & ~analog_enable[pin_idx[p]]; // RULE6
    assign periph_d[p] = route_live[p] ? pin_sync_q[pin_idx[p]]
                                       : remap_pkg::INACTIVE_LEVEL[p]; // RULE17 RULE18
  end

  // A pin is claimed when any live route selects it, so port logic yields
  // Claims ignore the pin level; an analog owner blocks the claim instead
  // Input-only pins are claimed too, which only tells port logic to stand back
  always_comb begin
    claim_d = '0;
    for (int p = 0; p < NI; p++) begin
      if (route_live[p]) begin
        claim_d[pin_idx[p]] = 1'b1; // RULE5 RULE17
      end
    end
  end

  // Reset leaves every field naming no pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= {NI{remap_pkg::SEL_RESET}}; // RULE4
      periph_q <= remap_pkg::INACTIVE_LEVEL;
      claim_q <= '0;
      rd_q <= '0;
    end else if (ce) begin
      sel_q <= sel_d;
      periph_q <= periph_d;
      claim_q <= claim_d;
      if (cfg_rd_en) begin
        rd_q <= rd_data_map(rd_word); // RULE19
      end
    end
  end

  function automatic logic [remap_pkg::REG_DATA_W-1:0] rd_data_map(input logic [WW-1:0] w);
    logic [remap_pkg::REG_DATA_W-1:0] d;
    d = '0;
    d[remap_pkg::LO_LSB +: SW] = w[SW-1:0];
    d[remap_pkg::HI_LSB +: SW] = w[WW-1:SW];
    return d;
  endfunction

  assign rd_word = word_of(cfg_rd_index, sel_q);

  // A full scan takes one cycle per register index, so an upset is caught
  // within that many cycles of clock enable being high
  // Shadow check walks one register per cycle; a write blanks the next compare,
  // since the shadow read returns the old word in that cycle
  assign shadow.wr_en = wr_ok;
  assign shadow.wr_addr = cfg_wr_index;
  assign shadow.wr_data = word_of(cfg_wr_index, sel_d);
  assign shadow.rd_addr = scan_q;
  assign scan_next = (scan_q == remap_pkg::REG_LAST) ? '0 : scan_q + 5'h01;
  assign cmp_word = word_of(cmp_idx_q, sel_q);
  assign mismatch_hit = cmp_ok_q && (cmp_word != shadow.rd_data); // RULE16 RULE13

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_q <= '0;
      cmp_idx_q <= '0;
      cmp_ok_q <= 1'b0;
      mismatch_q <= 1'b0;
    end else if (ce) begin
      scan_q <= scan_next;
      cmp_idx_q <= scan_q;
      cmp_ok_q <= ~wr_ok;
      // Held until reset; the reset controller consumes it
      mismatch_q <= mismatch_q | mismatch_hit; // RULE16
    end
  end

  // Only inputs are routed here; output routing lives in its own register set
  assign periph_in = periph_q; // RULE9 RULE10 RULE11
  // Input-only pins may be claimed, but nothing here ever drives a pin
  assign pin_remap_claim = claim_q; // RULE2 RULE3
  assign cfg_rd_data = rd_q;
  assign config_mismatch_reset = mismatch_q;

  // Field, write-path, routing and claim checks
  AST_LOCK_IGNORES: assert property (@(posedge clk) disable iff (rst) // RULE15
    ce && route_write_lock |=> $stable(sel_q))
    else $error("Locked write changed a route field");

  // The low half of register zero feeds the first input
  AST_WRITE_TAKES: assert property (@(posedge clk) disable iff (rst) // RULE7
    ce && wr_ok && cfg_wr_index == 5'h00 |=> sel_q[0] == $past(cfg_wr_data[5:0]))
    else $error("Unlocked write not taken into field");

  // The high half must land in the second input of the register
  AST_HIGH_HALF: assert property (@(posedge clk) disable iff (rst) // RULE8
    ce && wr_ok && cfg_wr_index == 5'h01
    |=> sel_q[1] == $past(cfg_wr_data[5:0]) && sel_q[2] == $past(cfg_wr_data[13:8]))
    else $error("Second field of a register not taken");

  // Right after reset nothing may be routed
  AST_NO_DEFAULT: assert property (@(posedge clk) disable iff (rst) // RULE4
    $past(rst) |-> sel_ok == '0 && periph_in == remap_pkg::INACTIVE_LEVEL)
    else $error("Input mapped right after reset");

  // A stalled clock enable must not let a field, routed input, claim or mismatch request drift
  AST_CE_FREEZE: assert property (@(posedge clk) disable iff (rst) // RULE13
    !ce |=> $stable(sel_q) && $stable(periph_in) && $stable(pin_remap_claim)
    && $stable(config_mismatch_reset))
    else $error("State moved while clock enable was low");

  // Unrouted inputs must rest at their idle level, not at a pin level
  AST_UNMAPPED_IDLE: assert property (@(posedge clk) disable iff (rst) // RULE18
    ce |=> (periph_in & ~$past(route_live)) == (remap_pkg::INACTIVE_LEVEL & ~$past(route_live)))
    else $error("Unmapped input not at inactive level");

  // Nothing routed means nothing claimed, so port logic keeps every pin
  AST_NO_CLAIM_UNMAPPED: assert property (@(posedge clk) disable iff (rst) // RULE4
    ce && route_live == '0 |=> pin_remap_claim == '0)
    else $error("Pin claimed with no live route");

  // Two inputs on one pin must see the same level
  AST_ROUTE_PIN: assert property (@(posedge clk) disable iff (rst) // RULE17
    ce && route_live[0] && route_live[1] && sel_q[0] == sel_q[1]
    |=> periph_in[0] == periph_in[1] && periph_in[0] == $past(pin_sync_q[pin_idx[0]]))
    else $error("Shared pin not fanned out");

  // Input-only pins feed a peripheral exactly like bidirectional ones
  AST_INPUT_ONLY_ROUTE: assert property (@(posedge clk) disable iff (rst) // RULE3
    ce && route_live[5] && sel_q[5] >= 6'(remap_pkg::NUM_BIDIR)
    |=> periph_in[5] == $past(pin_sync_q[pin_idx[5]]))
    else $error("Input-only pin not routed");

  // A live route always owns its pin, so port logic yields
  AST_CLAIM_MATCHES: assert property (@(posedge clk) disable iff (rst) // RULE5
    ce && route_live[0] |=> pin_remap_claim[$past(pin_idx[0])])
    else $error("Live route did not claim its pin");

  // An analog owner keeps the pin whatever the fields say
  AST_ANALOG_WINS: assert property (@(posedge clk) disable iff (rst) // RULE6
    ce |=> (pin_remap_claim & $past(analog_enable)) == '0)
    else $error("Remap claimed an analog pin");

  // Values past the last pin never route
  AST_INVALID_FIELD: assert property (@(posedge clk) disable iff (rst) // RULE14
    sel_q[0] > 6'h2D |-> !sel_ok[0] && !route_live[0])
    else $error("Out of range field treated as valid");

  // Unused bits of a readback must stay low
  AST_READBACK: assert property (@(posedge clk) disable iff (rst) // RULE19
    ce && cfg_rd_en && cfg_rd_index == 5'h00 |=> cfg_rd_data[5:0] == $past(sel_q[0])
    && cfg_rd_data[15:6] == '0)
    else $error("Readback differs from field");

  // Shadow scan and mismatch checks
  AST_MISMATCH_STICKY: assert property (@(posedge clk) disable iff (rst) // RULE16
    config_mismatch_reset |=> config_mismatch_reset)
    else $error("Mismatch reset request dropped");

  // Reset leaves the shadow in step, so no request follows it
  AST_MISMATCH_RESET: assert property (@(posedge clk) disable iff (rst) // RULE16
    $past(rst) |-> !config_mismatch_reset)
    else $error("Mismatch request right after reset");

  // The scan must wrap after the last register, or some words go unchecked
  AST_SCAN_WRAP: assert property (@(posedge clk) disable iff (rst) // RULE16
    ce && scan_q == remap_pkg::REG_LAST |=> scan_q == '0)
    else $error("Shadow scan did not wrap");

  // A matching compare must never raise the request
  AST_NO_FALSE_MISMATCH: assert property (@(posedge clk) disable iff (rst) // RULE13
    ce && !config_mismatch_reset && cmp_ok_q && cmp_word == shadow.rd_data
    |=> !config_mismatch_reset)
    else $error("Mismatch raised without a difference");

  // Coverage of the main scenarios
  COV_ROUTE: cover property (@(posedge clk) disable iff (rst)
    route_live[0] ##1 periph_in[0]);

  COV_LOCKED_WRITE: cover property (@(posedge clk) disable iff (rst)
    cfg_wr_en && route_write_lock);

  COV_SHARED_PIN: cover property (@(posedge clk) disable iff (rst)
    route_live[0] && route_live[4] && sel_q[0] == sel_q[4]);

  COV_ANALOG_BLOCK: cover property (@(posedge clk) disable iff (rst)
    sel_ok[0] && !route_live[0]);

  COV_INVALID_FIELD: cover property (@(posedge clk) disable iff (rst)
    !sel_ok[0] && sel_q[0] != remap_pkg::SEL_RESET);
endmodule

// >>> verification/pin_model.sv
// Far-side model: external drivers on the remappable pins
`timescale 1ns/1ps
module pin_model (
  input wire logic clk,
  input wire logic [remap_pkg::NUM_PINS-1:0] level_req,
  output logic [remap_pkg::NUM_PINS-1:0] pin_level
);
  // Levels settle just after an edge, so the sync stage never races the request
  always_ff @(posedge clk) begin
    pin_level <= level_req;
  end
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the peripheral input remap block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  typedef struct {logic [4:0] idx; logic [15:0] wdata; logic [15:0] rexp;} row_t;
  localparam logic [45:0] PAT = 46'h1555_5555_5555;
  localparam logic [45:0] PIN45 = 46'h2000_0000_0000;
  localparam logic [36:0] INACT = remap_pkg::INACTIVE_LEVEL;
  logic clk, rst, ce, lock, wr_en, rd_en;
  logic [4:0] wr_idx, rd_idx;
  logic [15:0] wr_data, rd_data, got;
  logic [45:0] pins_req, pins, analog, claim;
  logic [36:0] periph;
  logic mism;
  logic [15:0] used [30];
  logic [15:0] map [30];
  int n_mismatch = 0;
  int cmp_count = 0;
  // Register index, written value, expected readback
  row_t rows [5] = '{'{5'h00, 16'h0005, 16'h0005}, '{5'h01, 16'hFFFF, 16'h3F3F},
    '{5'h05, 16'h1234, 16'h0000}, '{5'h1D, 16'h2D2D, 16'h002D}, '{5'h1F, 16'h0101, 16'h0000}};
  peripheral_input_remap DUT (.clk(clk), .rst(rst), .ce(ce), .remap_pin_in(pins),
    .analog_enable(analog), .route_write_lock(lock), .cfg_wr_en(wr_en), .cfg_wr_index(wr_idx),
    .cfg_wr_data(wr_data), .cfg_rd_en(rd_en), .cfg_rd_index(rd_idx), .cfg_rd_data(rd_data),
    .periph_in(periph), .pin_remap_claim(claim), .config_mismatch_reset(mism));
  pin_model partner (.clk(clk), .level_req(pins_req), .pin_level(pins));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] i);
    @(posedge clk);
    rd_en <= 1'b1;
    rd_idx <= i;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 got = rd_data;
  endtask
  // Six edges cover the model flop, the two sync stages and the output flop
  task automatic set_pins(input logic [45:0] v, input logic [45:0] a);
    @(posedge clk);
    pins_req <= v;
    analog <= a;
    repeat (6) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    lock = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_idx = 5'h00;
    rd_idx = 5'h00;
    wr_data = 16'h0000;
    pins_req = '0;
    analog = '0;
    for (int r = 0; r < 30; r++) begin
      used[r] = 16'h0000;
      map[r] = 16'h0000;
    end
    for (int i = 0; i < remap_pkg::NUM_INPUTS; i++) begin
      if (remap_pkg::FIELD_HI[i]) begin
        used[remap_pkg::FIELD_REG[i]] |= 16'h3F00;
        map[remap_pkg::FIELD_REG[i]] |= 16'(i) << 8;
      end else begin
        used[remap_pkg::FIELD_REG[i]] |= 16'h003F;
        map[remap_pkg::FIELD_REG[i]] |= 16'(i);
      end
    end
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int r = 0; r < 30; r++) begin
      rd(5'(r));
      `CHK("reset readback", used[r], got)
    end
    set_pins('1, '0);
    `CHK("unrouted inputs", INACT, periph)
    `CHK("unrouted claim", 46'h0, claim)
    foreach (rows[k]) begin
      wr(rows[k].idx, rows[k].wdata);
      rd(rows[k].idx);
      `CHK("row readback", rows[k].rexp, got)
    end
    for (int r = 0; r < 30; r++) wr(5'(r), 16'h2D2D);
    set_pins(PIN45, '0);
    `CHK("fan out high", {37{1'b1}}, periph)
    `CHK("input only claim", PIN45, claim)
    set_pins('0, '0);
    `CHK("fan out low", 37'h0, periph)
    set_pins(PIN45, PIN45);
    `CHK("analog wins", INACT, periph)
    `CHK("analog claim", 46'h0, claim)
    wr(5'h00, 16'h002E);
    wr(5'h01, 16'h3F2E);
    set_pins('1, '0);
    `CHK("invalid fields", 4'h8, periph[3:0])
    for (int r = 0; r < 30; r++) wr(5'(r), map[r]);
    for (int r = 0; r < 30; r++) begin
      rd(5'(r));
      `CHK("map readback", map[r] & used[r], got)
    end
    set_pins(PAT, '0);
    `CHK("distinct routes", PAT[36:0], periph)
    `CHK("distinct claim", 46'h1F_FFFF_FFFF, claim)
    set_pins(~PAT, PAT);
    `CHK("mixed analog", (PAT[36:0] & INACT) | ~PAT[36:0], periph)
    `CHK("mixed claim", 46'h0A_AAAA_AAAA, claim)
    @(posedge clk);
    ce <= 1'b0;
    set_pins('0, '0);
    `CHK("frozen inputs", (PAT[36:0] & INACT) | ~PAT[36:0], periph)
    `CHK("frozen claim", 46'h0A_AAAA_AAAA, claim)
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    lock <= 1'b1;
    wr(5'h00, 16'h0009);
    rd(5'h00);
    `CHK("locked write", 16'h0000, got)
    @(posedge clk);
    lock <= 1'b0;
    wr(5'h00, 16'h0009);
    rd(5'h00);
    `CHK("unlocked write", 16'h0009, got)
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(5'h00);
    `CHK("second reset", 16'h003F, got)
    set_pins('1, '0);
    `CHK("second reset inputs", INACT, periph)
    `CHK("no mismatch", 1'b0, mism)
    conclude();
  end
endmodule
